// *** core/shr_pkg.sv ***
// Constants shared by the shift-stage block: register map, field
// positions, reset values and widths.
// Assumes a 32-bit APB bus with one aligned word per register.
package shr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_DATA   = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE     = 0;
    localparam int CTRL_WIPE     = 1;
    localparam int CTRL_LOAD_N   = 2;
    localparam int CTRL_PRESET   = 3;
    localparam int CTRL_PAR_IN   = 4;
    localparam int CTRL_W        = 5;
    localparam logic [4:0] CTRL_RESET = 5'h05;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int ST_DUAL_SO    = 0;
    localparam int ST_DUAL_SO_N  = 1;
    localparam int ST_CLR_SO     = 2;
    localparam int ST_CLR_TAP    = 3;
    localparam int ST_ALD_SO     = 4;
    localparam int ST_ALD_TAP    = 5;
    localparam int ST_EMPTY      = 6;
    localparam int ST_FULL       = 7;
    localparam int ST_BUSY       = 8;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int WORD_W        = 8;
    localparam int FIFO_DEPTH    = 16;
    localparam int CNT_W         = 4;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

endpackage

// *** core/shr_top.sv ***
// Three single-bit shift stages chained serially, fed from a word FIFO
// and controlled over APB.
// Assumes APB inputs are synchronous to pclk and follow APB signalling.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------
module shr_fifo #(
    parameter int WIDTH = shr_pkg::WORD_W,
    parameter int DEPTH = shr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    // Levels
    output logic                  full,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign empty     = (wr_q == rd_q);
    assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) &&
                       (wr_q[AW] != rd_q[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module shr_top #(
    parameter int WORD_W     = shr_pkg::WORD_W,
    parameter int FIFO_DEPTH = shr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Stage outputs
    output logic             dual_serial_out,
    output logic             serial_out_inverse,
    output logic             clr_serial_out,
    output logic             clr_parallel_tap,
    output logic             ald_serial_out,
    output logic             ald_parallel_tap
);
    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    logic [shr_pkg::CTRL_W-1:0] ctrl_q;
    logic [31:0]                prdata_q;
    logic                       pready_q;
    logic                       pslverr_q;
    logic                       fifo_in_ready;
    logic                       fifo_full;
    logic                       fifo_empty;
    logic                       fifo_out_valid;
    logic                       fifo_out_ready;
    logic [WORD_W-1:0]          fifo_out_data;
    logic                       busy_q;

    wire access   = psel && penable && !pready_q;
    wire finish   = psel && penable && pready_q;
    wire hit_ctrl = (paddr == shr_pkg::OFF_CTRL);
    wire hit_data = (paddr == shr_pkg::OFF_DATA);
    wire hit_stat = (paddr == shr_pkg::OFF_STATUS);
    wire mapped   = hit_ctrl || hit_data || hit_stat;
    // A data write stalls in the access phase until the FIFO has room.
    wire can_end  = !(pwrite && hit_data) || fifo_in_ready;
    wire ctrl_wr  = finish && pwrite && hit_ctrl;
    wire data_wr  = finish && pwrite && hit_data;

    wire mode_shift  = ctrl_q[shr_pkg::CTRL_MODE];
    wire wipe_input  = ctrl_q[shr_pkg::CTRL_WIPE];
    wire load_async_n = ctrl_q[shr_pkg::CTRL_LOAD_N];
    wire preset_value = ctrl_q[shr_pkg::CTRL_PRESET];
    wire parallel_in = ctrl_q[shr_pkg::CTRL_PAR_IN];
    // One net feeds both controls so they can never disagree.
    wire advance_enable = mode_shift;
    wire load_n         = mode_shift;

    logic [31:0] status;
    always_comb begin
        status = 32'h0000_0000;
        status[shr_pkg::ST_DUAL_SO]   = dual_serial_out;
        status[shr_pkg::ST_DUAL_SO_N] = serial_out_inverse;
        status[shr_pkg::ST_CLR_SO]    = clr_serial_out;
        status[shr_pkg::ST_CLR_TAP]   = clr_parallel_tap;
        status[shr_pkg::ST_ALD_SO]    = ald_serial_out;
        status[shr_pkg::ST_ALD_TAP]   = ald_parallel_tap;
        status[shr_pkg::ST_EMPTY]     = fifo_empty;
        status[shr_pkg::ST_FULL]      = fifo_full;
        status[shr_pkg::ST_BUSY]      = busy_q;
    end

    wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                         hit_stat ? status : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access && can_end;
            pslverr_q <= access && can_end && !mapped;
            prdata_q  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= shr_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[shr_pkg::CTRL_W-1:0];
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Word buffer and bit feeder
    // ------------------------------------------------------------
    shr_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) shr_fifo_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (data_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata[WORD_W-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    logic [WORD_W-1:0]         shift_q;
    logic [shr_pkg::CNT_W-1:0] cnt_q;

    // Words only drain in shift mode, so the FIFO fills while loading.
    assign fifo_out_ready = !busy_q && mode_shift;
    wire last_bit  = (cnt_q == shr_pkg::CNT_W'(WORD_W - 1));
    wire serial_in = busy_q && shift_q[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q  <= 1'b0;
            shift_q <= '0;
            cnt_q   <= shr_pkg::CNT_RESET;
        end else if (fifo_out_valid && fifo_out_ready) begin
            busy_q  <= 1'b1;
            shift_q <= fifo_out_data;
            cnt_q   <= shr_pkg::CNT_RESET;
        end else if (busy_q) begin
            busy_q  <= !last_bit;
            shift_q <= shift_q >> 1;
            cnt_q   <= cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Dual-mode stage
    // ------------------------------------------------------------
    // Mismatched controls cannot occur here; the stage would hold.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_serial_out    <= 1'b0;
            serial_out_inverse <= 1'b1;
        end else if (advance_enable && load_n) begin
            dual_serial_out    <= serial_in;
            serial_out_inverse <= !serial_in;
        end else if (!advance_enable && !load_n) begin
            dual_serial_out    <= parallel_in;
            serial_out_inverse <= !parallel_in;
        end
    end

    // ------------------------------------------------------------
    // Clearable serial stage
    // ------------------------------------------------------------
    // Wipe comes from a flip-flop, so it is glitch-free as a clear.
    wire clr_rst_n = presetn && !wipe_input;

    always_ff @(posedge pclk or negedge clr_rst_n) begin
        if (!clr_rst_n) begin
            clr_serial_out   <= 1'b0;
            clr_parallel_tap <= 1'b0;
        end else begin
            clr_serial_out   <= dual_serial_out;
            clr_parallel_tap <= dual_serial_out;
        end
    end

    // ------------------------------------------------------------
    // Asynchronous-load serial stage
    // ------------------------------------------------------------
    // The load is split into set and clear so each flop only ever
    // takes a constant asynchronously. Both terms come from control
    // flops that change on the same edge, which keeps them clean.
    wire ald_set_n = !(!load_async_n && preset_value);
    wire ald_clr_n = presetn && !(!load_async_n && !preset_value);

    always_ff @(posedge pclk or negedge ald_clr_n or negedge ald_set_n) begin
        if (!ald_clr_n) begin
            ald_serial_out   <= 1'b0;
            ald_parallel_tap <= 1'b0;
        end else if (!ald_set_n) begin
            ald_serial_out   <= 1'b1;
            ald_parallel_tap <= 1'b1;
        end else begin
            ald_serial_out   <= clr_serial_out;
            ald_parallel_tap <= clr_serial_out;
        end
    end
endmodule

// *** tb/shr_chain_sink.sv ***
// Next stage down the chain: collects eight bits LSB first.
// Assumes the word starts with a one bit after idle zeros.
`timescale 1ns/100ps
module shr_chain_sink (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Chain input
    input  wire logic       arm,
    input  wire logic       bit_in,
    // Collected word
    output logic      [7:0] word_q,
    output logic            done_q
);
    logic [3:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            word_q <= 8'h00;
            done_q <= 1'b0;
        end else if (!arm) begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end else if (!done_q && (cnt_q != 4'h0 || bit_in)) begin
            word_q <= {bit_in, word_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
            done_q <= (cnt_q == 4'h7);
        end
    end
endmodule

// *** tb/shr_props.sv ***
// Checker for the shift-stage block, bound to the top module's ports.
// Assumes control writes take effect on the edge where pready is high.
`timescale 1ns/100ps
module shr_props (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Stage outputs
    input wire logic        dual_serial_out,
    input wire logic        serial_out_inverse,
    input wire logic        clr_serial_out,
    input wire logic        clr_parallel_tap,
    input wire logic        ald_serial_out,
    input wire logic        ald_parallel_tap
);
    // ----------------------------------------------------------
    // Shadow of the control register
    // ----------------------------------------------------------
    logic [4:0] ctl_q;
    logic [4:0] ctl_d;
    wire        ctl_wr = psel && penable && pwrite && pready
                         && !pslverr && paddr == shr_pkg::OFF_CTRL;
    assign ctl_d = ctl_wr ? pwdata[4:0] : ctl_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= shr_pkg::CTRL_RESET;
        end else begin
            ctl_q <= ctl_d;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A wipe edge clears the stage between clocks, so the next stage
    // is only compared while wipe has held still.
    sequence ld_held;
        ctl_q[2] && !ctl_q[1] ##1 ctl_q[2] && $stable(ctl_q[1]);
    endsequence
    chk_inv_compl: assert property (
        serial_out_inverse != dual_serial_out) else $error("inverse bad");
    chk_clr_dup: assert property (
        clr_serial_out == clr_parallel_tap) else $error("clr tap bad");
    chk_ald_dup: assert property (
        ald_serial_out == ald_parallel_tap) else $error("ald tap bad");
    chk_wipe_zero: assert property (
        ctl_q[1] |-> !clr_serial_out && !clr_parallel_tap)
        else $error("wipe not low");
    chk_clr_shift: assert property (
        !ctl_q[1] && $past(!ctl_q[1]) |->
        clr_serial_out == $past(dual_serial_out)) else $error("clr shift");
    chk_ald_preset: assert property (
        !ctl_q[2] |-> ald_serial_out == ctl_q[3]) else $error("preset");
    chk_ald_shift: assert property (
        ld_held |-> ald_serial_out == $past(clr_serial_out))
        else $error("ald shift");
    chk_dual_load: assert property (
        !ctl_q[0] && $past(!ctl_q[0]) |->
        dual_serial_out == $past(ctl_q[4])) else $error("load bad");
    chk_err_with_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
endmodule

bind shr_top shr_props shr_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .dual_serial_out(dual_serial_out),
    .serial_out_inverse(serial_out_inverse),
    .clr_serial_out(clr_serial_out), .clr_parallel_tap(clr_parallel_tap),
    .ald_serial_out(ald_serial_out), .ald_parallel_tap(ald_parallel_tap));

// *** tb/shr_tb_top.sv ***
// Self-checking bench for the shift-stage block over APB.
// Assumes the checker is bound and the sink follows the last stage.
`timescale 1ns/100ps
module shr_tb_top;
    localparam logic [11:0] C = shr_pkg::OFF_CTRL;
    localparam logic [11:0] D = shr_pkg::OFF_DATA;
    localparam logic [11:0] S = shr_pkg::OFF_STATUS;
    logic        pclk, presetn, psel, penable, pwrite, arm;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, dso, dsi, cso, ctp, aso, atp, sd;
    logic [7:0]  sw;
    int          n_errors = 0;
    int          tests_run = 0;
    shr_top shr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dual_serial_out(dso),
        .serial_out_inverse(dsi), .clr_serial_out(cso),
        .clr_parallel_tap(ctp), .ald_serial_out(aso),
        .ald_parallel_tap(atp));
    shr_chain_sink shr_chain_sink_inst (.pclk(pclk), .presetn(presetn),
        .arm(arm), .bit_in(aso), .word_q(sw), .done_q(sd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(pready), 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_reset();
        chk({dso, dsi, cso, aso}, 4'h4);
        apb(1'b0, C, 32'h0);
        chk(rd, 32'(shr_pkg::CTRL_RESET));
    endtask

    // The mode bit drives shift enable and load strobe as one net.
    task automatic t_load_wipe();
        apb(1'b1, C, 32'h14);
        apb(1'b0, C, 32'h0);
        chk(rd, 32'h14);
        chk({dso, dsi, cso, ctp}, 4'hb);
        apb(1'b1, C, 32'h16);
        chk({dso, cso, ctp}, 3'h4);
    endtask

    task automatic t_preset();
        apb(1'b1, C, 32'h18);
        chk({aso, atp}, 2'h3);
        apb(1'b1, C, 32'h10);
        chk({cso, aso, atp}, 3'h4);
        apb(1'b1, C, 32'h14);
        @(posedge pclk);
        chk({aso, atp}, 2'h3);
    endtask

    task automatic t_fifo();
        int n;
        for (n = 0; n < 16; n++) apb(1'b1, D, 32'(n));
        apb(1'b0, S, 32'h0);
        chk(32'(rd[7:6]), 32'h2);
        apb(1'b0, D, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, C, 32'h05);
        n = 0;
        do begin
            apb(1'b0, S, 32'h0);
            n++;
        end while (rd[8:6] !== 3'h1 && n < 100);
        chk(32'(rd[8:6]), 32'h1);
    endtask

    task automatic t_shift();
        int n;
        n = 0;
        arm <= 1'b1;
        apb(1'b1, D, 32'hffffffa5);
        while (sd !== 1'b1 && n < 100) begin
            n++;
            @(posedge pclk);
        end
        chk(32'(sw), 32'ha5);
        arm <= 1'b0;
    endtask

    task automatic t_unmapped();
        apb(1'b1, 12'h00c, 32'h1f);
        chk(32'(er), 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, S, 32'h1f);
        chk(32'(er), 32'h0);
        apb(1'b0, C, 32'h0);
        chk({rd[30:0], er}, 32'ha);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        stop_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, arm} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_load_wipe();
        t_preset();
        t_fifo();
        t_shift();
        t_unmapped();
        stop_test();
    end
endmodule
